// >>> design/gpio_cfg_pkg.sv
// Package with constants, port identities and carrier structs for the port configuration block.
package gpio_cfg_pkg;

   localparam int PIN_COUNT = 8;

   typedef enum logic [2:0] {
      PORT_A,
      PORT_B,
      PORT_C,
      PORT_D,
      PORT_E,
      PORT_F,
      PORT_G,
      PORT_H
   } port_id_t;

   localparam logic [31:0] BASE_PORT_A = 32'h4000_4000;
   localparam logic [31:0] BASE_PORT_B = 32'h4000_5000;
   localparam logic [31:0] BASE_PORT_C = 32'h4000_6000;
   localparam logic [31:0] BASE_PORT_D = 32'h4000_7000;
   localparam logic [31:0] BASE_PORT_E = 32'h4002_4000;
   localparam logic [31:0] BASE_PORT_F = 32'h4002_5000;
   localparam logic [31:0] BASE_PORT_G = 32'h4002_6000;
   localparam logic [31:0] BASE_PORT_H = 32'h4002_7000;
   localparam logic [31:0] PORT_SPAN_MASK = 32'h0000_0fff;

   // Register offsets within one port window.
   localparam logic [11:0] OFS_DATA       = 12'h000;
   localparam logic [11:0] OFS_DIR        = 12'h400;
   localparam logic [11:0] OFS_SENSE      = 12'h404;
   localparam logic [11:0] OFS_BOTH       = 12'h408;
   localparam logic [11:0] OFS_EVENT      = 12'h40c;
   localparam logic [11:0] OFS_MASK       = 12'h410;
   localparam logic [11:0] OFS_ALT        = 12'h420;
   localparam logic [11:0] OFS_DRV_LOW    = 12'h500;
   localparam logic [11:0] OFS_DRV_MID    = 12'h504;
   localparam logic [11:0] OFS_DRV_HIGH   = 12'h508;
   localparam logic [11:0] OFS_OPEN_DRAIN = 12'h50c;
   localparam logic [11:0] OFS_PULL_UP    = 12'h510;
   localparam logic [11:0] OFS_PULL_DOWN  = 12'h514;
   localparam logic [11:0] OFS_SLEW       = 12'h518;
   localparam logic [11:0] OFS_DIG_EN     = 12'h51c;
   localparam logic [11:0] OFS_LOCK       = 12'h520;
   localparam logic [11:0] OFS_COMMIT     = 12'h524;
   localparam logic [11:0] OFS_DATA_LAST  = 12'h3fc;
   localparam int          DATA_MASK_LSB  = 2;

   localparam logic [31:0] UNLOCK_KEY    = 32'h1acc_e551;
   localparam logic [31:0] LOCK_READ_ON  = 32'h0000_0001;
   localparam logic [31:0] LOCK_READ_OFF = 32'h0000_0000;

   // Reset values and protected-pin masks; all but the low drive default depend on the debug pins.
   localparam logic [7:0] DEF_ALT_NONE     = 8'h00;
   localparam logic [7:0] DEF_ALT_PORT_B   = 8'h80;
   localparam logic [7:0] DEF_ALT_PORT_C   = 8'h0f;
   localparam logic [7:0] DEF_COMMIT_ALL   = 8'hff;
   localparam logic [7:0] DEF_COMMIT_B     = 8'h7f;
   localparam logic [7:0] DEF_COMMIT_C     = 8'hf0;
   localparam logic [7:0] PROTECT_NONE     = 8'h00;
   localparam logic [7:0] PROTECT_PORT_B   = 8'h80;
   localparam logic [7:0] PROTECT_PORT_C   = 8'h0f;
   localparam logic [7:0] DEF_DRIVE_LOW    = 8'hff;

   // Register bus request from the system bus master.
   typedef struct packed {
      logic        sel;
      logic        wr;
      logic [31:0] addr;
      logic [31:0] wdata;
   } bus_req_t;

   // Per-pin pad controls handed to the pad ring.
   typedef struct packed {
      logic [7:0] alt_func_select;
      logic [7:0] pin_direction;
      logic [7:0] open_drain_sel;
      logic [7:0] digital_enable_ctl;
      logic [7:0] pull_up_ctl;
      logic [7:0] pull_down_ctl;
      logic [7:0] drive_low_sel;
      logic [7:0] drive_mid_sel;
      logic [7:0] drive_high_sel;
      logic [7:0] slew_limit_sel;
   } pad_cfg_t;

   // Interrupt trigger setup for each pin.
   typedef struct packed {
      logic [7:0] int_sense_sel;
      logic [7:0] int_both_edges;
      logic [7:0] int_event_polarity;
      logic [7:0] int_pass_mask;
   } int_cfg_t;

   function automatic logic [31:0] port_base(input port_id_t id);
      unique case (id)
         PORT_A: port_base = BASE_PORT_A;
         PORT_B: port_base = BASE_PORT_B;
         PORT_C: port_base = BASE_PORT_C;
         PORT_D: port_base = BASE_PORT_D;
         PORT_E: port_base = BASE_PORT_E;
         PORT_F: port_base = BASE_PORT_F;
         PORT_G: port_base = BASE_PORT_G;
         PORT_H: port_base = BASE_PORT_H;
      endcase
   endfunction

   function automatic logic [7:0] alt_default(input port_id_t id);
      alt_default = (id == PORT_B) ? DEF_ALT_PORT_B :
                    (id == PORT_C) ? DEF_ALT_PORT_C : DEF_ALT_NONE;
   endfunction

   function automatic logic [7:0] commit_default(input port_id_t id);
      commit_default = (id == PORT_B) ? DEF_COMMIT_B :
                       (id == PORT_C) ? DEF_COMMIT_C : DEF_COMMIT_ALL;
   endfunction

   function automatic logic [7:0] protect_map(input port_id_t id);
      protect_map = (id == PORT_B) ? PROTECT_PORT_B :
                    (id == PORT_C) ? PROTECT_PORT_C : PROTECT_NONE;
   endfunction

endpackage

// >>> design/pin_sync.sv
// Two-stage synchroniser for the pad input levels.
`timescale 1ns/1ps
module pin_sync
   import gpio_cfg_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input  wire logic             sys_clk,
   input  wire logic             arst_n,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_t;

   sync_state_t state_q;
   sync_state_t state_d;

   always_comb begin
      state_d = state_q;
      if (clk_en) begin
         state_d.meta   = async_in;
         state_d.stable = state_q.meta;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign sync_out = state_q.stable;

endmodule

// >>> design/gpio_port_config_defaults.sv
// One general-purpose I/O port: register file, commit protection and pad control outputs.
`timescale 1ns/1ps

module gpio_port_config_defaults
   import gpio_cfg_pkg::*;
#(
   parameter port_id_t   PORT_ID   = PORT_A,
   parameter logic [7:0] PIN_MASK  = 8'hff
) (
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic        clk_en,
   input  wire bus_req_t    bus_req,
   input  wire logic [7:0]  pad_in,
   input  wire logic [7:0]  periph_out,
   input  wire logic [7:0]  periph_oe,
   output logic      [31:0] bus_rdata,
   output logic             bus_hit,
   output logic      [7:0]  pad_out,
   output logic      [7:0]  pad_oe,
   output pad_cfg_t         pad_cfg,
   output int_cfg_t         int_cfg,
   output logic      [7:0]  pin_level
);

   localparam logic [31:0] BASE      = port_base(PORT_ID);
   localparam logic [7:0]  PROTECTED = protect_map(PORT_ID);

   typedef struct packed {
      pad_cfg_t    pad;
      int_cfg_t    irq;
      logic [7:0]  data;
      logic [7:0]  commit;
      logic        unlocked;
      logic [31:0] rdata;
      logic        hit;
      logic [7:0]  out;
      logic [7:0]  oe;
      logic [7:0]  level;
   } port_state_t;

   port_state_t state_q;
   port_state_t state_d;
   logic [7:0]  pad_sync;
   logic [11:0] ofs;
   logic        in_window;

   pin_sync #(
      .WIDTH(PIN_COUNT)
   ) u_pin_sync (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .clk_en  (clk_en),
      .async_in(pad_in),
      .sync_out(pad_sync)
   );

   assign in_window = (bus_req.addr & ~PORT_SPAN_MASK) == BASE;
   assign ofs       = bus_req.addr[11:0];

   // Merge a write into a register, keeping only connected pins.
   function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v);
      merge = new_v & PIN_MASK;
      merge = merge | (old_v & ~PIN_MASK);
   endfunction

   always_comb begin
      logic       is_write;
      logic       is_data;
      logic [7:0] amask;
      logic [7:0] wv;
      logic [7:0] allowed;
      is_write = 1'b0;
      is_data  = 1'b0;
      amask    = '0;
      wv       = '0;
      allowed  = '0;
      state_d  = state_q;
      if (clk_en) begin
         is_write = bus_req.sel && bus_req.wr && in_window;
         is_data  = ofs <= OFS_DATA_LAST;
         amask    = bus_req.addr[DATA_MASK_LSB +: PIN_COUNT];
         wv       = bus_req.wdata[PIN_COUNT-1:0];
         state_d.hit   = bus_req.sel && in_window;
         state_d.rdata = '0;
         // Input pins capture the pad level every clk_en cycle without a data write; output pins hold software data.
         state_d.data = (state_q.data & state_q.pad.pin_direction)
                      | (pad_sync & ~state_q.pad.pin_direction & PIN_MASK);
         if (is_write) begin
            if (is_data) begin
               state_d.data = merge(state_q.data, (state_q.data & ~amask) | (wv & amask));
            end
            unique case (ofs)
               OFS_DIR:        state_d.pad.pin_direction = merge(state_q.pad.pin_direction, wv);
               OFS_SENSE:      state_d.irq.int_sense_sel = merge(state_q.irq.int_sense_sel, wv);
               OFS_BOTH:       state_d.irq.int_both_edges = merge(state_q.irq.int_both_edges, wv);
               OFS_EVENT:      state_d.irq.int_event_polarity =
                                  merge(state_q.irq.int_event_polarity, wv);
               OFS_MASK:       state_d.irq.int_pass_mask = merge(state_q.irq.int_pass_mask, wv);
               OFS_ALT: begin
                  // Protected bits change only while unlocked and committable.
                  allowed = ~PROTECTED | (state_q.commit & {PIN_COUNT{state_q.unlocked}});
                  state_d.pad.alt_func_select = merge(state_q.pad.alt_func_select,
                     (wv & allowed) | (state_q.pad.alt_func_select & ~allowed));
               end
               OFS_DRV_LOW:    state_d.pad.drive_low_sel = merge(state_q.pad.drive_low_sel, wv);
               OFS_DRV_MID:    state_d.pad.drive_mid_sel = merge(state_q.pad.drive_mid_sel, wv);
               OFS_DRV_HIGH:   state_d.pad.drive_high_sel = merge(state_q.pad.drive_high_sel, wv);
               OFS_OPEN_DRAIN: state_d.pad.open_drain_sel = merge(state_q.pad.open_drain_sel, wv);
               OFS_PULL_UP:    state_d.pad.pull_up_ctl = merge(state_q.pad.pull_up_ctl, wv);
               OFS_PULL_DOWN:  state_d.pad.pull_down_ctl = merge(state_q.pad.pull_down_ctl, wv);
               OFS_SLEW:       state_d.pad.slew_limit_sel = merge(state_q.pad.slew_limit_sel, wv);
               OFS_DIG_EN:     state_d.pad.digital_enable_ctl =
                                  merge(state_q.pad.digital_enable_ctl, wv);
               OFS_LOCK:       state_d.unlocked = bus_req.wdata == UNLOCK_KEY;
               OFS_COMMIT: begin
                  if (state_q.unlocked) begin
                     state_d.commit = (state_q.commit & ~PROTECTED)
                                    | (wv & PROTECTED & PIN_MASK);
                  end
               end
               default: ;
            endcase
         end else if (bus_req.sel && in_window) begin
            if (is_data) begin
               state_d.rdata[PIN_COUNT-1:0] = state_q.data & amask & PIN_MASK;
            end
            unique case (ofs)
               OFS_DIR:        state_d.rdata[7:0] = state_q.pad.pin_direction & PIN_MASK;
               OFS_SENSE:      state_d.rdata[7:0] = state_q.irq.int_sense_sel & PIN_MASK;
               OFS_BOTH:       state_d.rdata[7:0] = state_q.irq.int_both_edges & PIN_MASK;
               OFS_EVENT:      state_d.rdata[7:0] = state_q.irq.int_event_polarity & PIN_MASK;
               OFS_MASK:       state_d.rdata[7:0] = state_q.irq.int_pass_mask & PIN_MASK;
               OFS_ALT:        state_d.rdata[7:0] = state_q.pad.alt_func_select & PIN_MASK;
               OFS_DRV_LOW:    state_d.rdata[7:0] = state_q.pad.drive_low_sel & PIN_MASK;
               OFS_DRV_MID:    state_d.rdata[7:0] = state_q.pad.drive_mid_sel & PIN_MASK;
               OFS_DRV_HIGH:   state_d.rdata[7:0] = state_q.pad.drive_high_sel & PIN_MASK;
               OFS_OPEN_DRAIN: state_d.rdata[7:0] = state_q.pad.open_drain_sel & PIN_MASK;
               OFS_PULL_UP:    state_d.rdata[7:0] = state_q.pad.pull_up_ctl & PIN_MASK;
               OFS_PULL_DOWN:  state_d.rdata[7:0] = state_q.pad.pull_down_ctl & PIN_MASK;
               OFS_SLEW:       state_d.rdata[7:0] = state_q.pad.slew_limit_sel & PIN_MASK;
               OFS_DIG_EN:     state_d.rdata[7:0] = state_q.pad.digital_enable_ctl & PIN_MASK;
               OFS_LOCK:       state_d.rdata = state_q.unlocked ? LOCK_READ_OFF : LOCK_READ_ON;
               OFS_COMMIT:     state_d.rdata[7:0] = state_q.commit & PIN_MASK;
               default: ;
            endcase
         end
         // Peripheral owns pins under alternate select; disabled pins never drive.
         state_d.out = (state_q.pad.alt_func_select & periph_out)
                     | (~state_q.pad.alt_func_select & state_q.data);
         state_d.oe  = state_q.pad.digital_enable_ctl & PIN_MASK &
                       ((state_q.pad.alt_func_select & periph_oe)
                      | (~state_q.pad.alt_func_select & state_q.pad.pin_direction));
         // Open drain pins only pull low.
         state_d.oe  = state_d.oe & ~(state_q.pad.open_drain_sel & state_d.out);
         state_d.level = pad_sync & state_q.pad.digital_enable_ctl;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q                        <= '0;
         state_q.pad.alt_func_select    <= alt_default(PORT_ID) & PIN_MASK;
         state_q.pad.pull_up_ctl        <= alt_default(PORT_ID) & PIN_MASK;
         state_q.pad.digital_enable_ctl <= alt_default(PORT_ID) & PIN_MASK;
         state_q.pad.drive_low_sel      <= DEF_DRIVE_LOW & PIN_MASK;
         state_q.commit                 <= commit_default(PORT_ID) & PIN_MASK;
      end else begin
         state_q <= state_d;
      end
   end

   assign bus_rdata = state_q.rdata;
   assign bus_hit   = state_q.hit;
   assign pad_out   = state_q.out;
   assign pad_oe    = state_q.oe;
   assign pad_cfg   = state_q.pad;
   assign int_cfg   = state_q.irq;
   assign pin_level = state_q.level;

endmodule

// >>> sim/gpio_cfg_props.sv
// Concurrent checks on the ports of one configuration block.
`timescale 1ns/1ps
module gpio_cfg_props
   import gpio_cfg_pkg::*;
#(
   parameter port_id_t   PORT_ID  = PORT_A,
   parameter logic [7:0] PIN_MASK = 8'hff
) (
   input wire logic        sys_clk,
   input wire logic        arst_n,
   input wire logic        clk_en,
   input wire bus_req_t    bus_req,
   input wire logic [7:0]  periph_out,
   input wire logic [31:0] bus_rdata,
   input wire logic        bus_hit,
   input wire logic [7:0]  pad_out,
   input wire logic [7:0]  pad_oe,
   input wire pad_cfg_t    pad_cfg
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   logic       take;
   logic       rd_dir;
   logic       alt_wr;
   logic [7:0] prot_alt;
   assign take = clk_en && bus_req.sel
                 && ((bus_req.addr & ~PORT_SPAN_MASK) == port_base(PORT_ID));
   assign rd_dir = take && !bus_req.wr && (bus_req.addr[11:0] == OFS_DIR);
   assign alt_wr = take && bus_req.wr && (bus_req.addr[11:0] == OFS_ALT);
   assign prot_alt = pad_cfg.alt_func_select & protect_map(PORT_ID);
   hit_on_take_a: assert property (take |=> bus_hit) else $error("hit missing");
   hit_off_idle_a: assert property (!take && clk_en |=> !bus_hit) else $error("stray hit");
   rdata_idle_a: assert property (!(take && !bus_req.wr) && clk_en |=> bus_rdata == 32'h0)
      else $error("stray read data");
   dir_read_a: assert property (rd_dir |=> bus_rdata == {24'h0, $past(pad_cfg.pin_direction)})
      else $error("direction read wrong");
   rdata_unconn_a: assert property (bus_rdata[31:8] == 24'h0
      && (bus_rdata[7:1] & ~PIN_MASK[7:1]) == 7'h0) else $error("unconnected bit read");
   cfg_unconn_a: assert property (((pad_cfg.pin_direction | pad_cfg.pull_down_ctl)
      & ~PIN_MASK) == 8'h0) else $error("unconnected bit stored");
   oe_needs_den_a: assert property ($past(arst_n) |->
      (pad_oe & ~$past(pad_cfg.digital_enable_ctl)) == 8'h0) else $error("drive without enable");
   alt_periph_a: assert property ($past(arst_n) && $past(clk_en) |->
      ((pad_out ^ $past(periph_out)) & $past(pad_cfg.alt_func_select)) == 8'h0)
      else $error("peripheral value not on pad");
   alt_guard_a: assert property ($changed(prot_alt) |-> $past(alt_wr))
      else $error("protected select changed");
   reset_value_a: assert property ($rose(arst_n) |-> pad_cfg.pull_down_ctl == 8'h0
      && pad_cfg.alt_func_select == alt_default(PORT_ID)) else $error("reset value wrong");
   cover property (rd_dir ##1 bus_hit);
   cover property ($changed(prot_alt));
   cover property (alt_wr ##1 !bus_hit ##1 bus_hit);
endmodule
bind gpio_port_config_defaults gpio_cfg_props #(.PORT_ID(PORT_ID), .PIN_MASK(PIN_MASK)) u_props (
   .sys_clk(sys_clk),
   .arst_n(arst_n),
   .clk_en(clk_en),
   .bus_req(bus_req),
   .periph_out(periph_out),
   .bus_rdata(bus_rdata),
   .bus_hit(bus_hit),
   .pad_out(pad_out),
   .pad_oe(pad_oe),
   .pad_cfg(pad_cfg)
);

// >>> sim/tb.sv
// Self-checking bench for a port C instance with pin 7 left unconnected.
`timescale 1ns/1ps
module tb;
   import gpio_cfg_pkg::*;
   localparam logic [7:0]  PMSK = 8'h7f;
   localparam logic [31:0] BASE = BASE_PORT_C;
   logic        sys_clk;
   logic        arst_n;
   logic        clk_en;
   bus_req_t    bus_req;
   logic [7:0]  pad_in;
   logic [7:0]  periph_out;
   logic [7:0]  periph_oe;
   logic [31:0] bus_rdata;
   logic        bus_hit;
   logic [7:0]  pad_out;
   logic [7:0]  pad_oe;
   pad_cfg_t    pad_cfg;
   int_cfg_t    int_cfg;
   logic [7:0]  pin_level;
   int          n_mismatch;
   int          num_checks;
   integer      seed;
   logic [31:0] rd;
   logic        hit;
   logic [31:0] wd;
   logic [11:0] ofs;
   logic [11:0] tab [7] = '{OFS_DIR, OFS_SENSE, OFS_BOTH, OFS_EVENT, OFS_MASK, OFS_PULL_UP, OFS_SLEW};
   gpio_port_config_defaults #(.PORT_ID(PORT_C), .PIN_MASK(PMSK)) dut (
      .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .bus_req(bus_req),
      .pad_in(pad_in), .periph_out(periph_out), .periph_oe(periph_oe),
      .bus_rdata(bus_rdata), .bus_hit(bus_hit), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_cfg(pad_cfg), .int_cfg(int_cfg), .pin_level(pin_level));
   function automatic logic [31:0] conn(input logic [7:0] v);
      return {24'h0, v & PMSK};
   endfunction
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic acc(input logic wr, input logic [31:0] addr, input logic [31:0] data);
      @(posedge sys_clk);
      bus_req <= '{sel: 1'b1, wr: wr, addr: addr, wdata: data};
      @(posedge sys_clk);
      bus_req.sel <= 1'b0;
      #1;
      rd = bus_rdata;
      hit = bus_hit;
   endtask
   task automatic do_reset();
      arst_n <= 1'b0;
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      #1;
      cmp("alt", conn(8'h0f), {24'h0, pad_cfg.alt_func_select});
      cmp("pull_up", conn(8'h0f), {24'h0, pad_cfg.pull_up_ctl});
      cmp("den", conn(8'h0f), {24'h0, pad_cfg.digital_enable_ctl});
      cmp("pull_down", 32'h0, {24'h0, pad_cfg.pull_down_ctl});
      cmp("pad_oe", 32'h0, {24'h0, pad_oe});
      // Software keeps the settling gap after the port clock comes up.
      repeat (3) @(posedge sys_clk);
      acc(1'b0, BASE + OFS_COMMIT, 32'h0);
      cmp("commit", conn(8'hf0), rd);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // The whole sequence needs well under a tenth of this span.
   initial begin
      #200000;
      n_mismatch++;
      results();
   end
   initial begin
      seed = 89;
      n_mismatch = 0;
      num_checks = 0;
      arst_n = 1'b0;
      clk_en = 1'b1;
      bus_req = '0;
      pad_in = 8'h0;
      periph_out = 8'h0;
      periph_oe = 8'h0;
      do_reset();
      acc(1'b1, BASE + OFS_COMMIT, 32'h0);
      acc(1'b1, BASE + OFS_ALT, 32'h0);
      cmp("alt locked", conn(8'h0f), {24'h0, pad_cfg.alt_func_select});
      acc(1'b1, BASE + OFS_LOCK, UNLOCK_KEY);
      acc(1'b0, BASE + OFS_LOCK, 32'h0);
      cmp("lock open", LOCK_READ_OFF, rd);
      acc(1'b1, BASE + OFS_ALT, 32'h0);
      cmp("alt uncommitted", conn(8'h0f), {24'h0, pad_cfg.alt_func_select});
      acc(1'b1, BASE + OFS_COMMIT, 32'h0f);
      acc(1'b0, BASE + OFS_COMMIT, 32'h0);
      cmp("commit", conn(8'hff), rd);
      acc(1'b1, BASE + OFS_ALT, 32'h0);
      cmp("alt committed", 32'h0, {24'h0, pad_cfg.alt_func_select});
      acc(1'b1, BASE + OFS_LOCK, 32'h0);
      acc(1'b0, BASE + OFS_LOCK, 32'h0);
      cmp("lock shut", LOCK_READ_ON, rd);
      for (int i = 0; i < 40; i++) begin
         ofs = tab[$unsigned($random(seed)) % 7];
         wd = $random(seed);
         acc(1'b1, BASE + ofs, wd);
         acc(1'b0, BASE + ofs, 32'h0);
         cmp("readback", conn(wd[7:0]), rd);
      end
      acc(1'b1, BASE + OFS_SENSE, 32'h0);
      acc(1'b1, BASE + OFS_BOTH, 32'h0);
      acc(1'b1, BASE + OFS_EVENT, 32'h04);
      acc(1'b1, BASE + OFS_MASK, 32'h04);
      cmp("int_cfg", 32'h0000_0404, int_cfg);
      acc(1'b0, BASE_PORT_B + OFS_DIR, 32'h0);
      cmp("foreign hit", 32'h0, {31'h0, hit});
      acc(1'b0, BASE + 12'h600, 32'h0);
      cmp("hole hit", 32'h1, {31'h0, hit});
      cmp("hole data", 32'h0, rd);
      acc(1'b1, BASE + OFS_OPEN_DRAIN, 32'h0);
      acc(1'b1, BASE + OFS_DIR, 32'h01);
      acc(1'b1, BASE + OFS_DIG_EN, 32'h13);
      acc(1'b1, BASE + OFS_DATA_LAST, 32'hff);
      wd = $random(seed);
      pad_in <= wd[7:0];
      repeat (2) @(posedge sys_clk);
      #1;
      cmp("drive", 32'h3, {30'h0, pad_oe[0], pad_out[0]});
      repeat (4) @(posedge sys_clk);
      acc(1'b0, BASE + OFS_DATA_LAST, 32'h0);
      cmp("capture", {30'h0, wd[1], 1'b1}, {30'h0, rd[1:0]});
      cmp("pin_level", {24'h0, wd[7:0] & 8'h13}, {24'h0, pin_level});
      clk_en <= 1'b0;
      acc(1'b1, BASE + OFS_DIR, 32'hff);
      cmp("frozen dir", 32'h01, {24'h0, pad_cfg.pin_direction});
      clk_en <= 1'b1;
      acc(1'b1, BASE + OFS_ALT, 32'h10);
      periph_out <= wd[15:8];
      periph_oe <= wd[23:16];
      repeat (3) @(posedge sys_clk);
      #1;
      cmp("periph", {31'h0, wd[12]}, {31'h0, pad_out[4]});
      do_reset();
      results();
   end
endmodule
